// ==== design/sssc_device.sv ====
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
//
// Function
// - Read-only live surface address, resets zero
// - Activate settings at vblank/pipe/sprite off, armed
// - Only surface register write arms update
// - Resample source size to destination size
// - Upscale any, downscale to sixteen
// - Decimate by powers of two from 2x
// - No scaling with 64bpp source
// - Sizes at least 3x3, 3x6 interlaced
// - Dot clock limit from decimation, format
// - 64bpp planes at most 80% with sprite
// - Bit 31 enables scaling
// - Source width at most 4k bytes
// - Bits 30:29 select filter
// - Field offset bit picks phase 0/0.5
// - Adjust clear: phase is half scale
// - Adjust set: phase from offset bit
// - Bits 10:0 hold source height
// - Height programmed as lines minus one
// - Destination size fields, minus one
module sssc_device
    import sssc_pkg::*;
(
    input  wire logic        clk_i,          // Clock
    input  wire logic        rst_i,          // Async reset
    sssc_link_if.dev         lk,             // Link to pipe side
    output logic [31:0]      live_surf_o,    // Active surface base
    output logic             scale_on_o,     // Active scaling enable
    output logic [1:0]       filter_o,       // Active filter
    output logic [28:0]      h_step_o,       // Horizontal ratio 13.16
    output logic [28:0]      v_step_o,       // Vertical ratio 13.16
    output logic [2:0]       decim_log2_o,   // Horizontal decimation step
    output logic [28:0]      h_resid_o,      // Residual ratio
    output logic [28:0]      v_phase_o,      // Vertical initial phase 13.16
    output logic             params_ok_o,    // Ratios valid
    output logic             pix_valid_o,    // Output pixel strobe
    output logic [12:0]      src_x_o,        // Source pixel for it
    output logic             line_done_o     // Last pixel of line
);
    typedef struct packed {
        logic [31:0] scale_pend;
        logic [31:0] scale_act;
        logic [31:0] size_pend;
        logic [31:0] size_act;
        logic [31:0] surf_pend;
        logic [31:0] surf_act;
        logic        armed;
        logic [31:0] rdata;
        logic        div_go;
        logic        params_ok;
        logic [28:0] h_step;
        logic [28:0] v_step;
        logic [2:0]  decim;
        logic [28:0] h_resid;
        logic [28:0] v_phase;
        logic [1:0]  filter;
        logic        run;
        logic [28:0] pos;
        logic [12:0] cnt;
        logic        pix_v;
        logic [12:0] src_x;
        logic        line_done;
    } sssc_dev_t;

    sssc_dev_t   s_reg;
    sssc_dev_t   s_next;
    logic        upd;
    logic        surf_wr;
    logic        en_act;
    logic [12:0] src_w;
    logic [12:0] src_h;
    logic [12:0] dst_w;
    logic [12:0] dst_h;
    logic [28:0] qh;
    logic [28:0] qv;
    logic        done_h;
    logic [12:0] hint;
    logic [2:0]  dl;

    // ==========================================================
    // Actual sizes from minus-one fields
    assign en_act = s_reg.scale_act[SSSC_EN_BIT];
    assign src_w = 13'({2'b00, s_reg.scale_act[SSSC_SRCW_HI:SSSC_SRCW_LO]}) + 13'h0001;
    assign src_h = 13'({2'b00, s_reg.scale_act[SSSC_SRCH_HI:0]}) + 13'h0001;
    assign dst_w = 13'({1'b0, s_reg.size_act[SSSC_DSTW_HI:0]}) + 13'h0001;
    assign dst_h = 13'({1'b0, s_reg.size_act[SSSC_DSTH_HI:SSSC_DSTH_LO]}) + 13'h0001;

    // ==========================================================
    // Source over destination ratio per axis
    sssc_ratio_div #(.NW(13), .FW(SSSC_FRAC_W)) u_div_h (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (s_reg.div_go),
        .num_i   (src_w),
        .den_i   (dst_w),
        .quo_o   (qh),
        .done_o  (done_h)
    );

    sssc_ratio_div #(.NW(13), .FW(SSSC_FRAC_W)) u_div_v (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (s_reg.div_go),
        .num_i   (src_h),
        .den_i   (dst_h),
        .quo_o   (qv),
        .done_o  ()
    );

    // ==========================================================
    // Decimation step from integer ratio
    assign hint = qh[28:16];
    always_comb begin
        if (hint >= 13'(SSSC_MAX_DOWN)) begin
            dl = 3'h4;
        end else if (hint >= 13'h0008) begin
            dl = 3'h3;
        end else if (hint >= 13'h0004) begin
            dl = 3'h2;
        end else if (hint >= 13'h0002) begin
            dl = 3'h1;
        end else begin
            dl = 3'h0;
        end
    end

    // ==========================================================
    // Register access, arming and update point
    assign surf_wr = lk.wr && (lk.addr == SSSC_SURF_ARM_ADDR);
    assign upd = s_reg.armed && (lk.vblank_start || !lk.pipe_en || !lk.sprite_en);

    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;
        s_next.div_go = 1'b0;
        s_next.pix_v = 1'b0;
        s_next.line_done = 1'b0;
        if (lk.wr) begin
            case (lk.addr)
                SSSC_SCALE_ADDR: begin
                    s_next.scale_pend = lk.wdata & SSSC_SCALE_WMASK;
                end
                SSSC_DEST_SIZE_ADDR: begin
                    s_next.size_pend = lk.wdata & SSSC_SIZE_WMASK;
                end
                SSSC_SURF_ARM_ADDR: begin
                    s_next.surf_pend = lk.wdata & SSSC_SURF_WMASK;
                end
                default: begin
                end
            endcase
        end
        if (lk.rd) begin
            case (lk.addr)
                SSSC_SCALE_ADDR: begin
                    s_next.rdata = s_reg.scale_pend;
                end
                SSSC_DEST_SIZE_ADDR: begin
                    s_next.rdata = s_reg.size_pend;
                end
                SSSC_SURF_ARM_ADDR: begin
                    s_next.rdata = s_reg.surf_pend;
                end
                SSSC_LIVE_SURF_ADDR: begin
                    s_next.rdata = s_reg.surf_act;
                end
                default: begin
                    s_next.rdata = '0;
                end
            endcase
        end
        // New arm wins over the clearing update
        s_next.armed = (s_reg.armed && !upd) || surf_wr;
        if (upd) begin
            s_next.scale_act = s_reg.scale_pend;
            s_next.size_act = s_reg.size_pend;
            s_next.surf_act = s_reg.surf_pend;
            s_next.div_go = 1'b1;
            s_next.params_ok = 1'b0;
        end
        if (done_h) begin
            s_next.params_ok = 1'b1;
            if (en_act) begin
                s_next.h_step = qh;
                s_next.v_step = qv;
                s_next.decim = dl;
                s_next.h_resid = qh >> dl;
                s_next.filter = s_reg.scale_act[SSSC_FILT_HI:SSSC_FILT_LO];
                if (s_reg.scale_act[SSSC_FADJ_BIT]) begin
                    s_next.v_phase = s_reg.scale_act[SSSC_FOFF_BIT] ? SSSC_FX_HALF : '0;
                end else begin
                    s_next.v_phase = qv >> 1;
                end
            end else begin
                s_next.h_step = SSSC_FX_ONE;
                s_next.v_step = SSSC_FX_ONE;
                s_next.decim = '0;
                s_next.h_resid = SSSC_FX_ONE;
                s_next.filter = SSSC_FILT_MEDIUM;
                s_next.v_phase = '0;
            end
        end
        // Horizontal walk, one destination pixel a cycle
        if (lk.line_start && s_reg.params_ok && !s_reg.run) begin
            s_next.run = 1'b1;
            s_next.pos = '0;
            s_next.cnt = en_act ? dst_w - 13'h0001 : src_w - 13'h0001;
        end else if (s_reg.run) begin
            s_next.pix_v = 1'b1;
            s_next.src_x = s_reg.pos[28:16];
            s_next.pos = s_reg.pos + s_reg.h_step;
            if (s_reg.cnt == '0) begin
                s_next.run = 1'b0;
                s_next.line_done = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt - 13'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Outputs
    assign lk.rdata = s_reg.rdata;
    assign live_surf_o = s_reg.surf_act;
    assign scale_on_o = s_reg.scale_act[SSSC_EN_BIT];
    assign filter_o = s_reg.filter;
    assign h_step_o = s_reg.h_step;
    assign v_step_o = s_reg.v_step;
    assign decim_log2_o = s_reg.decim;
    assign h_resid_o = s_reg.h_resid;
    assign v_phase_o = s_reg.v_phase;
    assign params_ok_o = s_reg.params_ok;
    assign pix_valid_o = s_reg.pix_v;
    assign src_x_o = s_reg.src_x;
    assign line_done_o = s_reg.line_done;
endmodule

// ==== design/sssc_host.sv ====
`timescale 1ns/100ps
module sssc_host
    import sssc_pkg::*;
(
    input  wire logic        clk_i,          // Clock
    input  wire logic        rst_i,          // Async reset
    sssc_link_if.host        lk,             // Link to scaler
    input  wire logic [19:0] cmd_addr_i,     // Software address
    input  wire logic [31:0] cmd_wdata_i,    // Software write data
    input  wire logic        cmd_wr_i,       // Write strobe
    input  wire logic        cmd_rd_i,       // Read strobe
    output logic      [31:0] cmd_rdata_o,    // Read data, next cycle
    input  wire logic        vblank_start_i, // Vertical blank start pulse
    input  wire logic        pipe_en_i,      // Pipe enabled
    input  wire logic        sprite_en_i,    // Sprite enabled
    input  wire logic        line_start_i,   // Output line start pulse
    input  wire logic        interlaced_i,   // Pipe interlaced
    input  wire logic        fmt_64bpp_i,    // Sprite source is 64bpp
    input  wire logic        rgb_i,          // Sprite source is RGB
    input  wire logic        plane64_i,      // Some plane uses 64bpp
    input  wire logic        other_scale_i,  // Other pipe scales
    input  wire logic [3:0]  bytes_pp_i,     // Source bytes per pixel
    input  wire logic [6:0]  dot_pct_i,      // Dot clock, percent of core
    output logic             refused_o,      // Scaler write refused pulse
    output logic             dot_bad_o       // Dot clock over limit
);
    typedef struct packed {
        logic [31:0] size_sh;
        logic [31:0] scale_sh;
        logic        refused;
        logic        dot_bad;
    } sssc_host_t;

    sssc_host_t  s_reg;
    sssc_host_t  s_next;
    logic        en;
    logic [12:0] sw;
    logic [12:0] sh;
    logic [12:0] dw;
    logic [12:0] dh;
    logic [12:0] minh;
    logic        bad;
    logic [12:0] asw;
    logic [12:0] adw;
    logic [2:0]  k;
    logic [7:0]  base;
    logic [23:0] lhs;
    logic [23:0] rhs;

    // ==========================================================
    // Scaler write checks
    assign en = cmd_wdata_i[SSSC_EN_BIT];
    assign sw = 13'({2'b00, cmd_wdata_i[SSSC_SRCW_HI:SSSC_SRCW_LO]}) + 13'h0001;
    assign sh = 13'({2'b00, cmd_wdata_i[SSSC_SRCH_HI:0]}) + 13'h0001;
    assign dw = 13'({1'b0, s_reg.size_sh[SSSC_DSTW_HI:0]}) + 13'h0001;
    assign dh = 13'({1'b0, s_reg.size_sh[SSSC_DSTH_HI:SSSC_DSTH_LO]}) + 13'h0001;
    assign minh = interlaced_i ? SSSC_MIN_IL : SSSC_MIN_SIZE;
    assign bad = cmd_wr_i && (cmd_addr_i == SSSC_SCALE_ADDR) && en
        && (fmt_64bpp_i
        || sw < SSSC_MIN_SIZE || dw < SSSC_MIN_SIZE || sh < minh || dh < minh
        || 17'(sw) > 17'(dw) * 17'(SSSC_MAX_DOWN)
        || 17'(sh) > 17'(dh) * 17'(SSSC_MAX_DOWN)
        || 24'(sw) * 24'(bytes_pp_i) > SSSC_MAX_SRC_BYTES);

    // ==========================================================
    // Dot clock limit
    assign asw = 13'({2'b00, s_reg.scale_sh[SSSC_SRCW_HI:SSSC_SRCW_LO]}) + 13'h0001;
    assign adw = s_reg.scale_sh[SSSC_EN_BIT] ? dw : asw;
    always_comb begin
        k = '0;
        for (int i = 1; i <= 4; i++) begin
            if (17'(asw) >= (17'(adw) << i)) begin
                k = 3'(i);
            end
        end
        base = SSSC_DOT_BASE - 8'(k) * SSSC_DOT_STEP
            - (rgb_i ? SSSC_DOT_STEP : 8'h00) - (other_scale_i ? SSSC_DOT_STEP : 8'h00);
        lhs = 24'(dot_pct_i) * 24'(asw);
        rhs = 24'(base) * (24'(adw) << k);
    end

    always_comb begin
        s_next = s_reg;
        s_next.refused = bad;
        if (cmd_wr_i && cmd_addr_i == SSSC_DEST_SIZE_ADDR) begin
            s_next.size_sh = cmd_wdata_i;
        end
        if (cmd_wr_i && cmd_addr_i == SSSC_SCALE_ADDR && !bad) begin
            s_next.scale_sh = cmd_wdata_i;
        end
        s_next.dot_bad = (lhs > rhs)
            || (plane64_i && sprite_en_i && {1'b0, dot_pct_i} > SSSC_DOT_64);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Link drive; refused writes never reach the device
    assign lk.addr = cmd_addr_i;
    assign lk.wdata = cmd_wdata_i;
    assign lk.wr = cmd_wr_i && !bad;
    assign lk.rd = cmd_rd_i;
    assign lk.vblank_start = vblank_start_i;
    assign lk.pipe_en = pipe_en_i;
    assign lk.sprite_en = sprite_en_i;
    assign lk.line_start = line_start_i;
    assign cmd_rdata_o = lk.rdata;
    assign refused_o = s_reg.refused;
    assign dot_bad_o = s_reg.dot_bad;
endmodule

// ==== design/sssc_link_if.sv ====
`timescale 1ns/100ps
interface sssc_link_if (
    input wire logic clk_i,
    input wire logic rst_i
);
    logic [19:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wr;
    logic        rd;
    logic        vblank_start;
    logic        pipe_en;
    logic        sprite_en;
    logic        line_start;

    modport dev (input clk_i, rst_i, addr, wdata, wr, rd, vblank_start, pipe_en, sprite_en, line_start,
                 output rdata);
    modport host (input clk_i, rst_i, rdata,
                  output addr, wdata, wr, rd, vblank_start, pipe_en, sprite_en, line_start);
endinterface

// ==== design/sssc_pkg.sv ====
package sssc_pkg;
    // ==========================================================
    // Register byte addresses
    localparam logic [19:0] SSSC_LIVE_SURF_ADDR  = 20'h721AC;
    localparam logic [19:0] SSSC_SCALE_ADDR      = 20'h72204;
    localparam logic [19:0] SSSC_SURF_ARM_ADDR   = 20'h7219C;
    localparam logic [19:0] SSSC_DEST_SIZE_ADDR  = 20'h72190;
    // ==========================================================
    // Reset values and write masks
    localparam logic [31:0] SSSC_REG_RESET       = 32'h00000000;
    localparam logic [31:0] SSSC_SCALE_WMASK     = 32'hFFFF07FF;
    localparam logic [31:0] SSSC_SIZE_WMASK      = 32'h0FFF0FFF;
    localparam logic [31:0] SSSC_SURF_WMASK      = 32'hFFFFF000;
    // ==========================================================
    // Scaler control field positions
    localparam int SSSC_EN_BIT      = 31;
    localparam int SSSC_FILT_HI     = 30;
    localparam int SSSC_FILT_LO     = 29;
    localparam int SSSC_FOFF_BIT    = 28;
    localparam int SSSC_FADJ_BIT    = 27;
    localparam int SSSC_SRCW_HI     = 26;
    localparam int SSSC_SRCW_LO     = 16;
    localparam int SSSC_SRCH_HI     = 10;
    // Destination size field positions
    localparam int SSSC_DSTH_HI     = 27;
    localparam int SSSC_DSTH_LO     = 16;
    localparam int SSSC_DSTW_HI     = 11;
    // ==========================================================
    // Fixed point constants and limits
    localparam int          SSSC_FRAC_W   = 16;
    localparam logic [28:0] SSSC_FX_ONE   = 29'h0010000;
    localparam logic [28:0] SSSC_FX_HALF  = 29'h0008000;
    localparam logic [12:0] SSSC_MIN_SIZE = 13'h0003;
    localparam logic [12:0] SSSC_MIN_IL   = 13'h0006;
    localparam int          SSSC_MAX_DOWN = 16;
    localparam logic [23:0] SSSC_MAX_SRC_BYTES = 24'h001000;
    localparam logic [7:0]  SSSC_DOT_BASE = 8'h5A;
    localparam logic [7:0]  SSSC_DOT_STEP = 8'h0A;
    localparam logic [7:0]  SSSC_DOT_64   = 8'h50;
    // ==========================================================
    // Filter selection
    typedef enum logic [1:0] {
        SSSC_FILT_MEDIUM = 2'h0,
        SSSC_FILT_ENHANCE = 2'h1,
        SSSC_FILT_SOFTEN = 2'h2,
        SSSC_FILT_RSVD = 2'h3
    } sssc_filt_t;
endpackage

// ==== design/sssc_ratio_div.sv ====
`timescale 1ns/100ps
module sssc_ratio_div #(
    parameter int NW = 13,
    parameter int FW = 16
) (
    input  wire logic             clk_i,    // Clock
    input  wire logic             rst_i,    // Async reset
    input  wire logic             start_i,  // Start pulse
    input  wire logic [NW-1:0]    num_i,    // Source size
    input  wire logic [NW-1:0]    den_i,    // Destination size
    output logic      [NW+FW-1:0] quo_o,    // Ratio, FW fraction bits
    output logic                  done_o    // Result pulse
);
    localparam int QW = NW + FW;
    localparam int CW = $clog2(QW + 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
        logic [NW-1:0] den;
        logic [NW:0]   rem;
        logic [QW-1:0] dq;
        logic          done;
    } sssc_div_t;

    sssc_div_t s_reg;
    sssc_div_t s_next;
    logic [NW:0] r;
    logic        ge;

    // ==========================================================
    // Restoring division, one quotient bit a cycle
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        r = {s_reg.rem[NW-1:0], s_reg.dq[QW-1]};
        ge = r >= {1'b0, s_reg.den};
        if (start_i) begin
            s_next.busy = 1'b1;
            s_next.cnt = CW'(QW);
            s_next.den = den_i;
            s_next.rem = '0;
            s_next.dq = {num_i, {FW{1'b0}}};
        end else if (s_reg.busy) begin
            s_next.rem = ge ? r - {1'b0, s_reg.den} : r;
            s_next.dq = {s_reg.dq[QW-2:0], ge};
            s_next.cnt = s_reg.cnt - CW'(1);
            if (s_reg.cnt == CW'(1)) begin
                s_next.busy = 1'b0;
                s_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign quo_o = s_reg.dq;
    assign done_o = s_reg.done;
endmodule

// ==== dv/sprite_scaler_control_tb.sv ====
`timescale 1ns/100ps
module sprite_scaler_control_tb
    import sssc_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, cmd_wr_i = 1'b0, cmd_rd_i = 1'b0, vblank_start_i = 1'b0;
    logic        pipe_en_i = 1'b1, sprite_en_i = 1'b1, line_start_i = 1'b0, fmt_64bpp_i = 1'b0;
    logic        interlaced_i = 1'b0, rgb_i = 1'b0, plane64_i = 1'b0, other_scale_i = 1'b0;
    logic [3:0]  bytes_pp_i = 4'h4;
    logic [6:0]  dot_pct_i = 7'h00;
    logic [19:0] cmd_addr_i = 20'h0;
    logic [31:0] cmd_wdata_i = 32'h0, cmd_rdata_o, live_surf_o, live_exp = 32'h0;
    logic        refused_o, dot_bad_o, scale_on_o, params_ok_o, pix_valid_o, line_done_o;
    logic [1:0]  filter_o;
    logic [28:0] h_step_o, v_step_o, h_resid_o, v_phase_o;
    logic [2:0]  decim_log2_o;
    logic [12:0] src_x_o;
    int          err_total = 0, num_checks = 0, i, k, n, len;
    logic [31:0] t_scale [4] = '{32'hA07F007F, 32'hD87F007F, 32'h887F007F, 32'h607FF87F};
    logic [31:0] t_size  [4] = '{32'h003F003F, 32'h003F003F, 32'h00070007, 32'h000700FF};
    logic [28:0] t_step  [4] = '{29'h0020000, 29'h0020000, 29'h0100000, 29'h0010000};
    logic [28:0] t_phase [4] = '{29'h0010000, 29'h0008000, 29'h0000000, 29'h0000000};
    logic [2:0]  t_dec   [4] = '{3'h1, 3'h1, 3'h4, 3'h0};
    logic [6:0]  t_lim   [4] = '{7'h50, 7'h50, 7'h32, 7'h50};
    logic [31:0] t_ref   [4] = '{32'hA07F007F, 32'h8001007F, 32'h807F0090, 32'h87FF007F};
    always #4 clk_i = ~clk_i;
    // ==========================================================
    // Both ends and checker
    sssc_link_if sssc_link_if_inst (.clk_i, .rst_i);
    sssc_host sssc_host_inst (.clk_i, .rst_i, .lk(sssc_link_if_inst.host), .cmd_addr_i, .cmd_wdata_i, .cmd_wr_i,
        .cmd_rd_i, .cmd_rdata_o, .vblank_start_i, .pipe_en_i, .sprite_en_i, .line_start_i, .interlaced_i,
        .fmt_64bpp_i, .rgb_i, .plane64_i, .other_scale_i, .bytes_pp_i, .dot_pct_i, .refused_o, .dot_bad_o);
    sssc_device sssc_device_inst (.clk_i, .rst_i, .lk(sssc_link_if_inst.dev), .live_surf_o, .scale_on_o,
        .filter_o, .h_step_o, .v_step_o, .decim_log2_o, .h_resid_o, .v_phase_o, .params_ok_o, .pix_valid_o,
        .src_x_o, .line_done_o);
    sssc_chk sssc_chk_inst (.clk_i, .rst_i, .addr(sssc_link_if_inst.addr),
        .wdata(sssc_link_if_inst.wdata), .rdata(sssc_link_if_inst.rdata), .wr(sssc_link_if_inst.wr),
        .rd(sssc_link_if_inst.rd), .vblank_start(sssc_link_if_inst.vblank_start),
        .pipe_en(sssc_link_if_inst.pipe_en), .sprite_en(sssc_link_if_inst.sprite_en),
        .line_start(sssc_link_if_inst.line_start));
    // ==========================================================
    // Tasks
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [19:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cmd_addr_i <= a;
        cmd_wdata_i <= d;
        cmd_wr_i <= 1'b1;
        @(posedge clk_i);
        cmd_wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [19:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        cmd_addr_i <= a;
        cmd_rd_i <= 1'b1;
        @(posedge clk_i);
        cmd_rd_i <= 1'b0;
        #1 chk(what, cmd_rdata_o, exp);
    endtask
    task automatic upd(input int m);
        @(posedge clk_i);
        vblank_start_i <= (m == 0);
        sprite_en_i <= (m != 1);
        pipe_en_i <= (m != 2);
        @(posedge clk_i);
        vblank_start_i <= 1'b0;
        sprite_en_i <= 1'b1;
        pipe_en_i <= 1'b1;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk("live reset", SSSC_LIVE_SURF_ADDR, 32'h0);
        rd_chk("scale reset", SSSC_SCALE_ADDR, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr_reg(SSSC_DEST_SIZE_ADDR, t_size[i]);
            wr_reg(SSSC_SCALE_ADDR, t_scale[i]);
            rd_chk("scale read", SSSC_SCALE_ADDR, t_scale[i] & SSSC_SCALE_WMASK);
            if (i == 0) begin
                upd(0);
                repeat (3) @(posedge clk_i);
                #1 chk("unarmed enable", scale_on_o, 32'h0);
            end
            wr_reg(SSSC_SURF_ARM_ADDR, 32'h12345ABC + i);
            #1 chk("live held", live_surf_o, live_exp);
            live_exp = (32'h12345ABC + i) & SSSC_SURF_WMASK;
            upd(i % 3);
            #1 for (n = 0; n < 100 && params_ok_o !== 1'b1; n++) @(posedge clk_i) #1;
            chk("params ok", params_ok_o, 32'h1);
            chk("live port", live_surf_o, live_exp);
            chk("scale on", scale_on_o, t_scale[i][31]);
            chk("filter", filter_o, t_scale[i][31] ? t_scale[i][30:29] : 2'h0);
            chk("h step", h_step_o, t_step[i]);
            chk("v step", v_step_o, t_step[i]);
            chk("decim", decim_log2_o, t_dec[i]);
            chk("residue", h_resid_o, t_step[i] >> t_dec[i]);
            chk("phase", v_phase_o, t_phase[i]);
            rd_chk("live read", SSSC_LIVE_SURF_ADDR, live_exp);
            rd_chk("size read", SSSC_DEST_SIZE_ADDR, t_size[i]);
            for (k = 0; k < 2; k++) begin
                @(posedge clk_i) dot_pct_i <= t_lim[i] + 7'(k);
                plane64_i <= (i == 3);
                repeat (3) @(posedge clk_i);
                #1 chk("dot limit", dot_bad_o, k);
            end
            len = t_scale[i][31] ? t_size[i][11:0] + 1 : t_scale[i][26:16] + 1;
            @(posedge clk_i) line_start_i <= 1'b1;
            @(posedge clk_i) line_start_i <= 1'b0;
            k = 0;
            for (n = 0; n < 400 && k < len; n++) begin
                @(posedge clk_i) #1;
                if (pix_valid_o === 1'b1) begin
                    chk("source x", src_x_o, (k * t_step[i]) >> 16);
                    chk("line done", line_done_o, k == len - 1);
                    k++;
                end
            end
            if (k != len) begin
                chk("pixel count", k, len);
                results();
            end
            $display("scaling entry %0d done", i);
        end
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i) fmt_64bpp_i <= (i == 0);
            wr_reg(SSSC_SCALE_ADDR, t_ref[i]);
            #1 chk("refused", refused_o, 32'h1);
            rd_chk("scale kept", SSSC_SCALE_ADDR, t_scale[3] & SSSC_SCALE_WMASK);
        end
        $display("refusal test done");
        wr_reg(SSSC_LIVE_SURF_ADDR, 32'hFFFFFFFF);
        rd_chk("live read only", SSSC_LIVE_SURF_ADDR, live_exp);
        rd_chk("unmapped", 20'h72208, 32'h0);
        $display("access test done");
        results();
    end
endmodule

// ==== dv/sssc_chk.sv ====
`timescale 1ns/100ps
module sssc_chk
    import sssc_pkg::*;
(
    input wire logic        clk_i,        // Clock
    input wire logic        rst_i,        // Async reset
    input wire logic [19:0] addr,         // Address
    input wire logic [31:0] wdata,        // Write data
    input wire logic [31:0] rdata,        // Read data
    input wire logic        wr,           // Write strobe
    input wire logic        rd,           // Read strobe
    input wire logic        vblank_start, // Vblank pulse
    input wire logic        pipe_en,      // Pipe enabled
    input wire logic        sprite_en,    // Sprite enabled
    input wire logic        line_start    // Line start pulse
);
    logic [31:0] scale_reg;
    logic [31:0] size_reg;
    logic [31:0] surf_reg;
    logic [31:0] live_reg;
    logic        armed_reg;
    logic        upd;
    logic        mapped;
    assign upd = armed_reg && (vblank_start || !pipe_en || !sprite_en);
    assign mapped = addr inside {SSSC_LIVE_SURF_ADDR, SSSC_SCALE_ADDR, SSSC_SURF_ARM_ADDR, SSSC_DEST_SIZE_ADDR};
    // ==========================================================
    // Shadow registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scale_reg <= '0;
            size_reg  <= '0;
            surf_reg  <= '0;
            live_reg  <= '0;
            armed_reg <= 1'b0;
        end else begin
            if (wr && addr == SSSC_SCALE_ADDR) scale_reg <= wdata & SSSC_SCALE_WMASK;
            if (wr && addr == SSSC_DEST_SIZE_ADDR) size_reg <= wdata & SSSC_SIZE_WMASK;
            if (wr && addr == SSSC_SURF_ARM_ADDR) surf_reg <= wdata & SSSC_SURF_WMASK;
            if (upd) live_reg <= surf_reg;
            armed_reg <= (wr && addr == SSSC_SURF_ARM_ADDR) || (armed_reg && !upd);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // Assertions
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
        else $error("stray read data");
    a_scale_readback: assert property (rd && addr == SSSC_SCALE_ADDR |=> rdata == $past(scale_reg))
        else $error("scaler readback wrong");
    a_scale_rsvd: assert property (rd && addr == SSSC_SCALE_ADDR |=> rdata[15:11] == 5'h00)
        else $error("reserved bits set");
    a_field_bits: assert property (wr && addr == SSSC_SCALE_ADDR ##2 rd && addr == SSSC_SCALE_ADDR
        |=> rdata[30:27] == $past(wdata[30:27], 3))
        else $error("field bits lost");
    a_live_readback: assert property (rd && addr == SSSC_LIVE_SURF_ADDR |=> rdata == $past(live_reg))
        else $error("live address wrong");
    a_live_ro: assert property (wr && addr == SSSC_LIVE_SURF_ADDR && !armed_reg ##2 rd && addr == SSSC_LIVE_SURF_ADDR
        |=> rdata == $past(live_reg, 3))
        else $error("live address written");
    a_size_readback: assert property (rd && addr == SSSC_DEST_SIZE_ADDR |=> rdata == $past(size_reg))
        else $error("size readback wrong");
    a_unmapped_zero: assert property (rd && !mapped |=> rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule
